//--- core/rlrc_core.sv
`timescale 1ns/1ns
`include "rlrc_defs.svh"
module rlrc_core #(
    parameter int PC_W = `RLRC_PC_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic instr_valid_i,
    input wire rlrc_pkg::rlrc_instr_t instr_i,
    input wire logic [PC_W-1:0] stack_top_i,
    input wire rlrc_pkg::rlrc_fwr_t ext_wr_i,
    output logic ready_o,
    output logic done_o,
    output logic stack_pop_o,
    output logic [PC_W-1:0] pc_o,
    output logic [`RLRC_DATA_W-1:0] acc_o,
    output logic carry_o,
    output logic file_wr_o,
    output logic [`RLRC_FADDR_W-1:0] file_addr_o,
    output logic [`RLRC_DATA_W-1:0] file_data_o
);
    import rlrc_pkg::*;

    localparam logic [`RLRC_CNT_W-1:0] RET_LAST =
        `RLRC_CNT_W'(`RLRC_RET_ICYC * `RLRC_CLKS_PER_ICYC - 1);
    localparam logic [`RLRC_CNT_W-1:0] ROT_LAST =
        `RLRC_CNT_W'(`RLRC_ROT_ICYC * `RLRC_CLKS_PER_ICYC - 1);

    typedef struct packed {
        rlrc_state_e_t st;
        logic [`RLRC_CNT_W-1:0] cnt;
        rlrc_instr_t ins;
        logic ready;
        logic done;
        logic pop;
        logic [`RLRC_DATA_W-1:0] acc;
        logic carry;
        logic [PC_W-1:0] pc;
        rlrc_fwr_t fw;
    } rlrc_core_state_t;

    rlrc_core_state_t s_reg;
    rlrc_core_state_t s_next;
    logic [`RLRC_DATA_W-1:0] mem_rd;
    logic mem_we;
    logic [`RLRC_FADDR_W-1:0] mem_addr;
    logic [`RLRC_DATA_W-1:0] mem_wd;
    logic [`RLRC_DATA_W:0] rot_res;
    logic rot_c;
    logic [`RLRC_DATA_W-1:0] rot_r;

    // instruction length in clocks, minus one
    function automatic logic [`RLRC_CNT_W-1:0] last_tick(rlrc_op_t op);
        last_tick = (op == OP_RETURN_WITH_LITERAL) ? RET_LAST : ROT_LAST;
    endfunction : last_tick

    // returns {new carry, result}
    function automatic logic [`RLRC_DATA_W:0] rotate(
        input logic [`RLRC_DATA_W-1:0] d,
        input logic c,
        input logic left
    );
        if (left) begin
            rotate = {d[`RLRC_DATA_W-1], d[`RLRC_DATA_W-2:0],
                c};
        end else begin
            rotate = {d[0], c, d[`RLRC_DATA_W-1:1]};
        end
    endfunction : rotate

    // file port is shared: outside writes only while idle, so a rotate
    // never sees its operand change under it
    always_comb begin
        if (s_reg.st == ST_IDLE) begin
            mem_we = ext_wr_i.we;
            mem_addr = ext_wr_i.addr;
            mem_wd = ext_wr_i.data;
        end else begin
            mem_we = s_next.fw.we;
            mem_addr = s_reg.ins.faddr;
            mem_wd = s_next.fw.data;
        end
    end

    rlrc_file_mem #(
        .DATA_W(`RLRC_DATA_W),
        .ADDR_W(`RLRC_FADDR_W),
        .DEPTH(`RLRC_FREG_DEPTH)
    ) u_fmem (
        .ref_clk_i(ref_clk_i),
        .we_i(mem_we),
        .addr_i(mem_addr),
        .wdata_i(mem_wd),
        .rdata_o(mem_rd)
    );

    assign rot_res = rotate(mem_rd, s_reg.carry,
        s_reg.ins.op == OP_ROTATE_LEFT_CARRY);
    assign {rot_c, rot_r} = rot_res;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.pop = 1'b0;
        s_next.fw.we = 1'b0;
        unique case (s_reg.st)
            ST_IDLE: begin
                if (instr_valid_i) begin
                    s_next.st = ST_EXEC;
                    s_next.cnt = '0;
                    s_next.ins = instr_i;
                    s_next.ready = 1'b0;
                end
            end
            ST_EXEC: begin
                if (s_reg.cnt == last_tick(s_reg.ins.op)) begin
                    s_next.st = ST_IDLE;
                    s_next.ready = 1'b1;
                    s_next.done = 1'b1;
                    unique case (s_reg.ins.op)
                        OP_RETURN_WITH_LITERAL: begin
                            s_next.acc = s_reg.ins.lit;
                            s_next.pc = stack_top_i;
                            s_next.pop = 1'b1;
                        end
                        OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY: begin
                            s_next.carry = rot_c;
                            s_next.fw.addr = s_reg.ins.faddr;
                            s_next.fw.data = rot_r;
                            if (s_reg.ins.dest == `RLRC_DEST_FREG) begin
                                s_next.fw.we = 1'b1;
                            end else begin
                                s_next.acc = rot_r;
                            end
                        end
                        // undefined opcode retires with no effect
                        OP_UNUSED: begin
                        end
                    endcase
                end else begin
                    s_next.cnt = s_reg.cnt + `RLRC_CNT_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_reg <= '{st: ST_IDLE, ready: 1'b1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign ready_o = s_reg.ready;
    assign done_o = s_reg.done;
    assign stack_pop_o = s_reg.pop;
    assign pc_o = s_reg.pc;
    assign acc_o = s_reg.acc;
    assign carry_o = s_reg.carry;
    assign file_wr_o = s_reg.fw.we;
    assign file_addr_o = s_reg.fw.addr;
    assign file_data_o = s_reg.fw.data;

    // assertion helpers
    logic acc_ret;
    logic acc_rot;
    logic done_ret;
    logic done_rol;
    logic done_ror;
    assign acc_ret = ready_o && instr_valid_i
        && instr_i.op == OP_RETURN_WITH_LITERAL;
    assign acc_rot = ready_o && instr_valid_i
        && (instr_i.op == OP_ROTATE_LEFT_CARRY
        || instr_i.op == OP_ROTATE_RIGHT_CARRY);
    assign done_ret = done_o && s_reg.ins.op == OP_RETURN_WITH_LITERAL;
    assign done_rol = done_o && s_reg.ins.op == OP_ROTATE_LEFT_CARRY;
    assign done_ror = done_o && s_reg.ins.op == OP_ROTATE_RIGHT_CARRY;

    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence ret_runs;
        (!done_o)[*8] ##1 done_o;
    endsequence

    sequence rot_runs;
        (!done_o)[*4] ##1 done_o;
    endsequence

    a_ret_timing: assert property (
        acc_ret |=> ret_runs)
        else $error("return took wrong number of clocks");

    a_ret_load: assert property (
        acc_ret |-> ##9 (acc_o == $past(instr_i.lit, 9)))
        else $error("accumulator not loaded with literal");

    a_ret_pc_pop: assert property (
        done_ret |-> stack_pop_o && pc_o == $past(stack_top_i))
        else $error("pc not taken from stack top");

    a_ret_flags: assert property (
        done_ret |-> carry_o == $past(carry_o) && !file_wr_o)
        else $error("return changed carry or file");

    a_rot_timing: assert property (
        acc_rot |=> rot_runs)
        else $error("rotate took wrong number of clocks");

    a_rol_value: assert property (
        done_rol |-> {carry_o, file_data_o}
            == {$past(mem_rd), $past(carry_o)})
        else $error("left rotate result wrong");

    a_ror_value: assert property (
        done_ror |-> {file_data_o, carry_o}
            == {$past(carry_o), $past(mem_rd)})
        else $error("right rotate result wrong");

    a_rot_dest: assert property (
        (done_rol || done_ror) |-> (s_reg.ins.dest
            ? (file_wr_o && acc_o == $past(acc_o))
            : (!file_wr_o && acc_o == file_data_o)))
        else $error("rotate result sent to wrong place");
endmodule : rlrc_core

//--- core/rlrc_defs.svh
// Overview of operation
// - return_with_literal loads the accumulator with its 8-bit literal.
// - return_with_literal reloads the program counter from stack_top.
// - return_with_literal: one word, 2 instr cycles, no flag change.
// - rotate_left_carry: shift file reg left, carry in bit 0, bit 7 out.
// - rotate_left_carry: dest 0 writes accumulator, dest 1 the file reg.
// - rotate_right_carry: shift right, carry in bit 7, bit 0 to carry.
// - rotate_right_carry: dest 0 writes accumulator, dest 1 file reg.
`ifndef RLRC_DEFS_SVH
`define RLRC_DEFS_SVH
`define RLRC_DATA_W 8
`define RLRC_FADDR_W 7
`define RLRC_FREG_DEPTH 128
`define RLRC_PC_W 15
`define RLRC_CNT_W 3
`define RLRC_CLKS_PER_ICYC 4
`define RLRC_RET_ICYC 2
`define RLRC_ROT_ICYC 1
`define RLRC_DEST_ACC 1'b0
`define RLRC_DEST_FREG 1'b1
`endif

//--- core/rlrc_file_mem.sv
`timescale 1ns/1ns
`include "rlrc_defs.svh"
module rlrc_file_mem #(
    parameter int DATA_W = `RLRC_DATA_W,
    parameter int ADDR_W = `RLRC_FADDR_W,
    parameter int DEPTH = `RLRC_FREG_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic [DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] mem [DEPTH];

    // read-before-write: a write shows on rdata one edge later
    always_ff @(posedge ref_clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule : rlrc_file_mem

//--- core/rlrc_pkg.sv
`include "rlrc_defs.svh"
package rlrc_pkg;
    typedef enum logic [1:0] {
        OP_RETURN_WITH_LITERAL = 2'b00,
        OP_ROTATE_LEFT_CARRY = 2'b01,
        OP_ROTATE_RIGHT_CARRY = 2'b10,
        OP_UNUSED = 2'b11
    } rlrc_op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } rlrc_state_e_t;

    typedef struct packed {
        rlrc_op_t op;
        logic [`RLRC_DATA_W-1:0] lit;
        logic [`RLRC_FADDR_W-1:0] faddr;
        logic dest;
    } rlrc_instr_t;

    typedef struct packed {
        logic we;
        logic [`RLRC_FADDR_W-1:0] addr;
        logic [`RLRC_DATA_W-1:0] data;
    } rlrc_fwr_t;

    typedef struct packed {
        rlrc_state_e_t st;
        logic [`RLRC_CNT_W-1:0] cnt;
        rlrc_instr_t ins;
        logic ready;
        logic done;
        logic pop;
        logic [`RLRC_DATA_W-1:0] acc;
        logic carry;
        logic [`RLRC_PC_W-1:0] pc;
        rlrc_fwr_t fw;
    } rlrc_state_t;
endpackage : rlrc_pkg

//--- tb/return_literal_rotate_carry_tb.sv
`timescale 1ns/1ns
`include "rlrc_defs.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR %0t: got %h want %h", $time, (a), (e)); end end
module return_literal_rotate_carry_tb;
    import rlrc_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic instr_valid_i = 1'b0;
    rlrc_instr_t instr_i = '0;
    logic [14:0] stack_top_i = '0;
    rlrc_fwr_t ext_wr_i = '0;
    logic ready_o, done_o, stack_pop_o, carry_o, file_wr_o;
    logic [14:0] pc_o;
    logic [7:0] acc_o, file_data_o;
    logic [6:0] file_addr_o;
    int n_errors = 0;
    int compares = 0;
    logic timed_out = 1'b0;
    // mirror of the file registers, acc, carry and pc
    logic [7:0] mem [128];
    logic [7:0] m_acc = 8'h00;
    logic m_c = 1'b0;
    logic [14:0] m_pc = 15'h0000;

    rlrc_core dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .stack_top_i(stack_top_i), .ext_wr_i(ext_wr_i), .ready_o(ready_o),
        .done_o(done_o), .stack_pop_o(stack_pop_o), .pc_o(pc_o),
        .acc_o(acc_o), .carry_o(carry_o), .file_wr_o(file_wr_o),
        .file_addr_o(file_addr_o), .file_data_o(file_data_o));

    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // returns {new carry, result}
    function automatic logic [8:0] rot(input logic [7:0] d, input logic c,
        input logic left);
        return left ? {d[7], d[6:0], c} : {d[0], c, d[7:1]};
    endfunction : rot

    task automatic complete_run();
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    task automatic run(input rlrc_op_t op, input logic [7:0] lit,
        input logic [6:0] fa, input logic d, input logic pre);
        int n;
        int want;
        logic is_rot;
        logic [8:0] r;
        if (timed_out) begin
            return;
        end
        is_rot = op inside {OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY};
        stack_top_i = 15'($urandom);
        instr_i = '{op, lit, fa, d};
        instr_valid_i = 1'b1;
        if (pre) begin
            // a preload in the take cycle must land before the read
            ext_wr_i = '{1'b1, fa, ~lit};
            mem[fa] = ~lit;
        end
        @(posedge ref_clk_i);
        #1;
        // junk offered while busy must be ignored
        instr_i.lit = 8'($urandom);
        ext_wr_i = '{1'b1, 7'($urandom), 8'($urandom)};
        n = 1;
        while (done_o !== 1'b1 && n < 20) begin
            `CHK(ready_o, 1'b0)
            @(posedge ref_clk_i);
            #1;
            // lowered once only, so a next call may raise it at once
            if (n == 1) begin
                instr_valid_i = 1'b0;
                ext_wr_i.we = 1'b0;
            end
            n++;
        end
        if (n >= 20) begin
            n_errors++;
            timed_out = 1'b1;
            return;
        end
        want = (op == OP_RETURN_WITH_LITERAL) ? 9 : 5;
        `CHK(n, want)
        if (op == OP_RETURN_WITH_LITERAL) begin
            m_acc = lit;
            m_pc = stack_top_i;
        end else if (is_rot) begin
            r = rot(mem[fa], m_c, op == OP_ROTATE_LEFT_CARRY);
            m_c = r[8];
            if (d) begin
                mem[fa] = r[7:0];
            end else begin
                m_acc = r[7:0];
            end
            `CHK(file_addr_o, fa)
            `CHK(file_data_o, r[7:0])
        end
        `CHK(acc_o, m_acc)
        `CHK(carry_o, m_c)
        `CHK(pc_o, m_pc)
        `CHK(stack_pop_o, op == OP_RETURN_WITH_LITERAL)
        `CHK(file_wr_o, is_rot && d)
        `CHK(ready_o, 1'b1)
    endtask : run

    initial begin
        void'($urandom(32'h60a2));
        repeat (20) @(posedge ref_clk_i);
        #1;
        `CHK({ready_o, done_o, stack_pop_o, file_wr_o}, 4'h8)
        `CHK({acc_o, carry_o, pc_o}, 24'h000000)
        rst_i = 1'b0;
        for (int i = 0; i < 128; i++) begin
            ext_wr_i = '{1'b1, 7'(i), (i == 5) ? 8'he6 : 8'($urandom)};
            mem[i] = ext_wr_i.data;
            @(posedge ref_clk_i);
            #1;
        end
        ext_wr_i.we = 1'b0;
        run(OP_ROTATE_LEFT_CARRY, 8'h00, 7'h05, 1'b0, 1'b0);
        `CHK(acc_o, 8'hcc)
        `CHK(carry_o, 1'b1)
        // every op and dest at the end values of literal and address
        for (int i = 0; i < 16; i++) begin
            run(rlrc_op_t'(i % 4), (i & 4) ? 8'hff : 8'h00,
                (i & 4) ? 7'h7f : 7'h00, i[3], i[1]);
        end
        repeat (300) begin
            run(rlrc_op_t'($urandom_range(0, 3)), 8'($urandom), 7'($urandom),
                1'($urandom), 1'($urandom));
        end
        complete_run();
    end
endmodule : return_literal_rotate_carry_tb
